// ### adcc_pkg.sv
// What this block does
// (RQ1) Ten-bit successive approximation, one input
// (RQ2) Eight pin channels, ground and bandgap
// (RQ3) Channel and reference apply only when enabled
// (RQ4) Right-aligned result, left when selected
// (RQ5) Low byte read locks until high read
// (RQ6) Result lost when completing while locked
// (RQ7) Done flag still set when result lost
// (RQ8) Start bit high until conversion finishes
// (RQ9) Software clears power gate before use
// (RQ10) Channel change waits for running conversion
// (RQ11) Auto trigger starts from selected event
// (RQ12) Trigger edge resets prescaler, starts conversion
// (RQ13) Only rising edges start; busy edges ignored
// (RQ14) Trigger flags count even with interrupts off
// (RQ15) Software clears trigger flag between events
// (RQ16) Done-flag source restarts after every conversion
// (RQ17) Software starts first free-running conversion
// (RQ18) Start bit works and reads busy always
// (RQ19) Left-aligned eight bits: read high only
// (RQ20) Disable converter before sleep to save power
// (RQ21) Thirteen cycles, first conversion twenty-five
// (RQ22) Prescaler held reset while converter disabled
// (RQ23) Software start waits next converter clock edge
// (RQ24) Left: high holds bits nine to two
package adcc_pkg;

    // -------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int PRESC_W = 8;
    localparam int TCNT_W = 5;
    localparam int TRIG_N = 8;

    // -------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------
    localparam logic [2:0] OFS_INPUT_SEL = 3'h0;
    localparam logic [2:0] OFS_CTRL_A = 3'h1;
    localparam logic [2:0] OFS_CTRL_B = 3'h2;
    localparam logic [2:0] OFS_RES_LOW = 3'h3;
    localparam logic [2:0] OFS_RES_HIGH = 3'h4;
    localparam logic [2:0] OFS_POWER = 3'h5;

    // -------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------
    localparam int BIT_EN = 7;
    localparam int BIT_START = 6;
    localparam int BIT_ATE = 5;
    localparam int BIT_FLAG = 4;
    localparam int BIT_IE = 3;
    localparam int BIT_GATE = 0;
    localparam logic [7:0] RST_INPUT_SEL = 8'h00;
    localparam logic [2:0] RST_PRESC = 3'h0;
    localparam logic [2:0] RST_TSEL = 3'h0;
    localparam logic RST_GATE = 1'b1;
    localparam logic [2:0] TSEL_FREE_RUN = 3'h0;

    // -------------------------------------------------------------
    // Conversion timing in converter clock cycles
    // -------------------------------------------------------------
    localparam int CONV_NORMAL = 13;
    localparam int CONV_FIRST = 25;
    localparam int SAMPLE_TICK = 1;
    localparam logic [TCNT_W-1:0] FIRST_EXTRA =
        TCNT_W'(CONV_FIRST - CONV_NORMAL);
    localparam logic [TCNT_W-1:0] DONE_TICK = TCNT_W'(CONV_NORMAL - 1);

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef struct packed {
        logic [1:0] ref_sel;
        logic left_adj;
        logic rsvd;
        logic [3:0] chan;
    } adcc_mux_s;

    typedef enum logic [0:0] {
        SAR_IDLE = 1'b0,
        SAR_RUN = 1'b1
    } adcc_sar_e;

    // Places the result in the high or low byte
    function automatic logic [7:0] adcc_align(input logic [9:0] res,
                                              input logic left,
                                              input logic high);
        logic [15:0] word;
        word = left ? {res, 6'h00} : {6'h00, res};
        return high ? word[15:8] : word[7:0];
    endfunction

endpackage

// ### adcc_prescaler.sv
`timescale 1ns/1ns
module adcc_prescaler
    import adcc_pkg::*;
#(
    parameter int W = PRESC_W
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic clear_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] last;

    // Division by 2, 4, ... 256
    assign last = W'((2 << sel_i) - 1);

    // Counter held in reset while cleared
    always_ff @(posedge core_clk_i) begin
        if (srst_i || clear_i) begin // RQ22
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
            tick_o <= 1'b0;
        end
    end

endmodule // adcc_prescaler

// ### adcc_sar.sv
`timescale 1ns/1ns
module adcc_sar
    import adcc_pkg::*;
#(
    parameter int RES = RES_W
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic first_i,
    input wire logic cmp_i,
    output logic busy_o,
    output logic sample_o,
    output logic done_o,
    output logic [RES-1:0] dac_o
);

    adcc_sar_e state_reg;
    logic [TCNT_W-1:0] cnt_reg;
    logic [TCNT_W-1:0] offs;
    logic first_reg;
    logic [RES-1:0] mask_reg;

    assign offs = first_reg ? FIRST_EXTRA : '0;
    assign busy_o = (state_reg == SAR_RUN);

    // Sequencer: sample, one trial per tick, then done
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_reg <= SAR_IDLE;
            cnt_reg <= '0;
            first_reg <= 1'b0;
            mask_reg <= '0;
            dac_o <= '0;
            sample_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state_reg)
                SAR_IDLE: begin
                    if (start_i && tick_i) begin // RQ23
                        state_reg <= SAR_RUN;
                        // Start tick counts as tick one of the conversion
                        cnt_reg <= TCNT_W'(1);
                        first_reg <= first_i;
                        sample_o <= 1'b1;
                    end
                end
                SAR_RUN: begin
                    if (tick_i) begin
                        cnt_reg <= cnt_reg + TCNT_W'(1);
                        if (cnt_reg == offs + TCNT_W'(SAMPLE_TICK)) begin
                            sample_o <= 1'b0;
                            mask_reg <= {1'b1, {(RES-1){1'b0}}};
                            dac_o <= {1'b1, {(RES-1){1'b0}}};
                        end else if (mask_reg != '0) begin
                            // Keep or drop the trial bit, try the next
                            dac_o <= (cmp_i ? dac_o : dac_o & ~mask_reg)
                                     | (mask_reg >> 1); // RQ1
                            mask_reg <= mask_reg >> 1;
                        end else if (cnt_reg == offs + DONE_TICK) begin
                            state_reg <= SAR_IDLE; // RQ21
                            done_o <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

endmodule // adcc_sar

// ### adcc_top.sv
`timescale 1ns/1ns
module adcc_top
    import adcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic [TRIG_N-1:0] trig_i,
    input wire logic cmp_i,
    output logic [3:0] chan_o,
    output logic [1:0] ref_o,
    output logic [RES_W-1:0] dac_o,
    output logic sample_o,
    output logic power_o,
    output logic irq_o
);

    // -------------------------------------------------------------
    // Software state
    // -------------------------------------------------------------
    adcc_mux_s input_select_reg;
    logic converter_enable_reg;
    logic auto_trigger_enable_reg;
    logic conversion_done_flag_reg;
    logic irq_enable_reg;
    logic [2:0] presc_sel_reg;
    logic [2:0] trigger_source_select_reg;
    logic converter_power_gate_reg;

    // -------------------------------------------------------------
    // Conversion state
    // -------------------------------------------------------------
    logic start_req_reg;
    logic first_reg;
    logic lock_reg;
    logic [RES_W-1:0] result_reg;
    logic trig_prev_reg;

    // -------------------------------------------------------------
    // Internal wires
    // -------------------------------------------------------------
    logic active;
    logic tick;
    logic busy;
    logic done;
    logic [RES_W-1:0] sar_code;
    logic trig_level;
    logic trig_edge;
    logic auto_start;
    logic free_restart;
    logic start_go;
    logic sw_start;
    logic rd_low;
    logic rd_high;
    logic result_update;
    logic presc_clear;
    logic sar_reset;
    logic [DATA_W-1:0] read_value;

    // Register access decode
    function automatic logic hit(input logic strobe,
                                 input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] ofs);
        return strobe && (addr == ofs);
    endfunction

    // -------------------------------------------------------------
    // Enable and start decisions
    // -------------------------------------------------------------

    // Converter runs only when enabled and not power gated
    assign active = converter_enable_reg
                    && !converter_power_gate_reg; // RQ9

    // Software start request
    assign sw_start = hit(wr_i, addr_i, OFS_CTRL_A)
                      && wdata_i[BIT_START] && active; // RQ8

    // Selected trigger level; flag levels come in regardless of enables
    assign trig_level =
        (trigger_source_select_reg == TSEL_FREE_RUN)
        ? conversion_done_flag_reg
        : trig_i[trigger_source_select_reg]; // RQ14

    // Rising edge only
    assign trig_edge = trig_level && !trig_prev_reg; // RQ13

    // Edge accepted only when idle in auto-trigger mode
    assign auto_start = active && auto_trigger_enable_reg
                        && (trigger_source_select_reg != TSEL_FREE_RUN)
                        && trig_edge && !busy
                        && !start_req_reg; // RQ11 RQ13

    // Free running restarts on every completion
    assign free_restart = active && auto_trigger_enable_reg
                          && (trigger_source_select_reg == TSEL_FREE_RUN)
                          && done; // RQ16

    // Request taken at the next converter clock edge
    assign start_go = start_req_reg && tick && !busy; // RQ23

    // Trigger edge restarts the prescaler for a fixed delay
    assign presc_clear = !active || auto_start; // RQ12 RQ22

    // Disabling aborts any conversion
    assign sar_reset = srst_i || !active;

    // -------------------------------------------------------------
    // Result access
    // -------------------------------------------------------------
    assign rd_low = hit(rd_i, addr_i, OFS_RES_LOW);
    assign rd_high = hit(rd_i, addr_i, OFS_RES_HIGH);

    // No update while locked or while the low byte is being read
    assign result_update = done && !lock_reg && !rd_low; // RQ6

    // -------------------------------------------------------------
    // Submodules
    // -------------------------------------------------------------

    // Converter clock divider
    adcc_prescaler #(
        .W(PRESC_W)
    ) u_presc (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .clear_i(presc_clear),
        .sel_i(presc_sel_reg),
        .tick_o(tick)
    );

    // Approximation sequencer
    adcc_sar #(
        .RES(RES_W)
    ) u_sar (
        .core_clk_i(core_clk_i),
        .srst_i(sar_reset),
        .tick_i(tick),
        .start_i(start_req_reg),
        .first_i(first_reg),
        .cmp_i(cmp_i),
        .busy_o(busy),
        .sample_o(sample_o),
        .done_o(done),
        .dac_o(sar_code)
    );

    assign dac_o = sar_code;

    // -------------------------------------------------------------
    // Software writable registers
    // -------------------------------------------------------------

    // Input select register
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            input_select_reg <= adcc_mux_s'(RST_INPUT_SEL);
        end else if (hit(wr_i, addr_i, OFS_INPUT_SEL)) begin
            input_select_reg <= adcc_mux_s'(wdata_i);
            input_select_reg.rsvd <= 1'b0;
        end
    end

    // Control A fields other than start and flag
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            converter_enable_reg <= 1'b0;
            auto_trigger_enable_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            presc_sel_reg <= RST_PRESC;
        end else if (hit(wr_i, addr_i, OFS_CTRL_A)) begin
            converter_enable_reg <= wdata_i[BIT_EN];
            auto_trigger_enable_reg <= wdata_i[BIT_ATE];
            irq_enable_reg <= wdata_i[BIT_IE];
            presc_sel_reg <= wdata_i[2:0];
        end
    end

    // Control B trigger source
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            trigger_source_select_reg <= RST_TSEL;
        end else if (hit(wr_i, addr_i, OFS_CTRL_B)) begin
            trigger_source_select_reg <= wdata_i[2:0];
        end
    end

    // Power gate, set after reset
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            converter_power_gate_reg <= RST_GATE;
        end else if (hit(wr_i, addr_i, OFS_POWER)) begin
            converter_power_gate_reg <= wdata_i[BIT_GATE]; // RQ9
        end
    end

    // -------------------------------------------------------------
    // Conversion control
    // -------------------------------------------------------------

    // Pending start: software, trigger edge or free-running restart
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !active) begin
            start_req_reg <= 1'b0;
        end else if (sw_start || auto_start || free_restart) begin
            start_req_reg <= 1'b1; // RQ8 RQ12 RQ16 RQ18
        end else if (start_go) begin
            start_req_reg <= 1'b0;
        end
    end

    // Next conversion is the long first one after enabling
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !active) begin
            first_reg <= 1'b1; // RQ21
        end else if (start_go) begin
            first_reg <= 1'b0;
        end
    end

    // Previous trigger level for edge detection
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_level; // RQ13
        end
    end

    // Done flag: completion sets, write one clears, set wins
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            conversion_done_flag_reg <= 1'b0;
        end else if (done) begin
            conversion_done_flag_reg <= 1'b1; // RQ7
        end else if (hit(wr_i, addr_i, OFS_CTRL_A)
                     && wdata_i[BIT_FLAG]) begin
            conversion_done_flag_reg <= 1'b0;
        end
    end

    // Interrupt request follows flag and enable
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= conversion_done_flag_reg && irq_enable_reg; // RQ7
        end
    end

    // -------------------------------------------------------------
    // Result and read lock
    // -------------------------------------------------------------

    // Lock set by low byte read, released by high byte read
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            lock_reg <= 1'b0;
        end else if (rd_low) begin
            lock_reg <= 1'b1; // RQ5
        end else if (rd_high) begin
            lock_reg <= 1'b0; // RQ5
        end
    end

    // Result capture, dropped while locked
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            result_reg <= '0;
        end else if (result_update) begin
            result_reg <= sar_code; // RQ1 RQ6
        end
    end

    // -------------------------------------------------------------
    // Analog side selection
    // -------------------------------------------------------------

    // Selection follows software only when enabled and idle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            chan_o <= '0;
            ref_o <= '0;
        end else if (active && !busy && !start_go) begin
            chan_o <= input_select_reg.chan; // RQ2 RQ3 RQ10
            ref_o <= input_select_reg.ref_sel; // RQ3
        end
    end

    // Analog power follows the effective enable
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            power_o <= 1'b0;
        end else begin
            power_o <= active;
        end
    end

    // -------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------

    // Read value selection; reserved bits read zero
    always_comb begin
        read_value = '0;
        unique case (addr_i)
            OFS_INPUT_SEL: begin
                read_value = input_select_reg;
            end
            OFS_CTRL_A: begin
                read_value = {converter_enable_reg,
                              start_req_reg || busy || done, // RQ8 RQ18
                              auto_trigger_enable_reg,
                              conversion_done_flag_reg,
                              irq_enable_reg,
                              presc_sel_reg};
            end
            OFS_CTRL_B: begin
                read_value = {5'h00, trigger_source_select_reg};
            end
            OFS_RES_LOW: begin
                read_value = adcc_align(result_reg,
                                        input_select_reg.left_adj,
                                        1'b0); // RQ4 RQ24
            end
            OFS_RES_HIGH: begin
                read_value = adcc_align(result_reg,
                                        input_select_reg.left_adj,
                                        1'b1); // RQ4 RQ24
            end
            OFS_POWER: begin
                read_value = {7'h00, converter_power_gate_reg};
            end
            default: begin
                read_value = '0;
            end
        endcase
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= read_value;
        end else begin
            rdata_o <= '0;
        end
    end

endmodule // adcc_top

// ### adcc_analog_model.sv
`timescale 1ns/1ns
module adcc_analog_model
    import adcc_pkg::*;
#(
    parameter logic [9:0] BANDGAP = 10'h15a
) (
    input wire logic core_clk_i,
    input wire logic [79:0] pins_i,
    input wire logic [3:0] chan_i,
    input wire logic [RES_W-1:0] dac_i,
    input wire logic sample_i,
    output logic cmp_o
);
    logic [9:0] held = 10'h000;

    // Track the selected input while sampling, hold it afterwards
    always_ff @(posedge core_clk_i) begin
        if (sample_i) begin
            if (chan_i < 4'h8) begin
                held <= pins_i[chan_i*10 +: 10];
            end else begin
                held <= (chan_i == 4'he) ? BANDGAP : 10'h000;
            end
        end
    end

    // Comparator: input at or above the trial code
    assign cmp_o = held >= dac_i;
endmodule // adcc_analog_model

// ### adcc_top_assertions.sv
`timescale 1ns/1ns
module adcc_top_chk
    import adcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic [3:0] chan_o,
    input wire logic [1:0] ref_o,
    input wire logic sample_o,
    input wire logic power_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    // -------------------------------------------------------------
    // Steps of a select write followed by its read back
    // -------------------------------------------------------------
    sequence s_sel_wr;
        wr_i && addr_i == OFS_INPUT_SEL;
    endsequence
    sequence s_sel_rd;
        rd_i && addr_i == OFS_INPUT_SEL;
    endsequence

    a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside answer");
    a_unmapped_zero: assert property (rd_i && addr_i > 3'h5
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    a_sel_readback: assert property (s_sel_wr ##2 s_sel_rd
        |=> rdata_o == ($past(wdata_i, 3) & 8'hef))
        else $error("select read back wrong");
    a_enable_off: assert property (wr_i && addr_i == OFS_CTRL_A
        && !wdata_i[BIT_EN] |=> ##1 !power_o) else $error("still powered");
    a_gate_on: assert property (wr_i && addr_i == OFS_POWER
        && wdata_i[BIT_GATE] |=> ##1 !power_o) else $error("gate ignored");
    a_power_cause: assert property ($rose(power_o) |-> $past(wr_i, 2))
        else $error("power rose without a write");
    a_sel_held_off: assert property (!power_o [*3]
        |-> $stable({chan_o, ref_o})) else $error("select moved while off");
    a_chan_locked: assert property (sample_o && $past(sample_o)
        |-> $stable({chan_o, ref_o})) else $error("select moved in sample");
    a_sample_off: assert property (!power_o [*2] |-> !sample_o)
        else $error("sampling while disabled");
endmodule // adcc_top_chk

bind adcc_top adcc_top_chk u_chk (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .chan_o(chan_o),
    .ref_o(ref_o),
    .sample_o(sample_o),
    .power_o(power_o)
);

// ### tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb;
    import adcc_pkg::*;
    logic core_clk_i, srst_i, wr_i, rd_i, cmp_i, sample_o, power_o, irq_o;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, trig_i, d;
    logic [3:0] chan_o;
    logic [1:0] ref_o;
    logic [9:0] dac_o, old;
    logic [79:0] pins;
    logic [2:0] ch;
    logic lft;
    int failures, total_checks, cyc, seed;

    adcc_top uut (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .trig_i(trig_i), .cmp_i(cmp_i),
        .chan_o(chan_o), .ref_o(ref_o), .dac_o(dac_o),
        .sample_o(sample_o), .power_o(power_o), .irq_o(irq_o));
    adcc_analog_model u_ana (.core_clk_i(core_clk_i), .pins_i(pins),
        .chan_i(chan_o), .dac_i(dac_o), .sample_i(sample_o), .cmp_o(cmp_i));

    // Clock and hang limit
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            test_done;
        end
    end

    // Expected result byte for either alignment
    function automatic logic [7:0] exp_byte(input logic [9:0] r,
                                            input logic l, input logic h);
        if (l) return h ? r[9:2] : {r[1:0], 6'h00};
        return h ? {6'h00, r[9:8]} : r[7:0];
    endfunction

    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(negedge core_clk_i);
        v = rdata_o;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        d = 8'hff;
        while (d[BIT_START] !== 1'b0 && n < 300) begin
            bus_rd(OFS_CTRL_A, d);
            n++;
        end
        `CHK(d[BIT_START], 1'b0)
        `CHK(d[BIT_FLAG], 1'b1)
    endtask

    // One software conversion on channel ch, result read low then high
    task automatic conv;
        bus_wr(OFS_INPUT_SEL, {2'h1, lft, 2'h0, ch});
        bus_wr(OFS_CTRL_A, 8'hd8);
        bus_rd(OFS_CTRL_A, d);
        `CHK(d[BIT_START], 1'b1)
        wait_idle;
        `CHK(irq_o, 1'b1)
        bus_rd(OFS_RES_LOW, d);
        `CHK(d, exp_byte(pins[ch*10 +: 10], lft, 1'b0))
        bus_rd(OFS_RES_HIGH, d);
        `CHK(d, exp_byte(pins[ch*10 +: 10], lft, 1'b1))
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h51a1;
        {srst_i, wr_i, rd_i, addr_i, wdata_i, trig_i} = '0;
        srst_i = 1'b1;
        for (int k = 0; k < 8; k++) pins[k*10 +: 10] = 10'($random(seed));
        pins[9:0] = 10'h000;
        pins[79:70] = 10'h3ff;
        repeat (8) @(posedge core_clk_i);
        srst_i <= 1'b0;
        bus_rd(OFS_POWER, d);
        `CHK(d[BIT_GATE], RST_GATE)
        bus_rd(OFS_CTRL_B, d);
        `CHK(d[2:0], RST_TSEL)
        bus_wr(3'h7, 8'hff);
        bus_rd(3'h7, d);
        `CHK(d, 8'h00)
        bus_wr(OFS_INPUT_SEL, 8'h53);
        bus_rd(OFS_INPUT_SEL, d);
        `CHK(d, 8'h43)
        `CHK(chan_o, 4'h0)
        bus_wr(OFS_CTRL_A, 8'hc0);
        bus_rd(OFS_CTRL_A, d);
        `CHK(d[BIT_START], 1'b0)
        bus_wr(OFS_POWER, 8'h00);
        bus_wr(OFS_CTRL_A, 8'h88);
        `CHK(chan_o, 4'h3)
        `CHK(ref_o, 2'h1)
        for (int i = 0; i < 8; i++) begin
            ch = (i < 2) ? 3'(i * 7) : 3'($random(seed));
            lft = (i < 2) ? 1'(i) : 1'($random(seed));
            conv;
        end
        // A locked result survives a later conversion
        bus_rd(OFS_RES_LOW, d);
        old = pins[ch*10 +: 10];
        pins[ch*10 +: 10] = ~old;
        bus_wr(OFS_CTRL_A, 8'hd8);
        wait_idle;
        bus_rd(OFS_RES_HIGH, d);
        `CHK(d, exp_byte(old, lft, 1'b1))
        bus_rd(OFS_RES_LOW, d);
        `CHK(d, exp_byte(old, lft, 1'b0))
        bus_rd(OFS_RES_HIGH, d);
        bus_wr(OFS_CTRL_A, 8'h98);
        repeat (2) @(negedge core_clk_i);
        `CHK(irq_o, 1'b0)
        // Edge trigger: busy edges and held level start nothing
        bus_wr(OFS_CTRL_B, 8'h01);
        bus_wr(OFS_CTRL_A, 8'hb8);
        trig_i[1] <= 1'b1;
        bus_rd(OFS_CTRL_A, d);
        `CHK(d[BIT_START], 1'b1)
        trig_i[1] <= 1'b0;
        @(posedge core_clk_i);
        trig_i[1] <= 1'b1;
        wait_idle;
        repeat (80) @(posedge core_clk_i);
        bus_rd(OFS_CTRL_A, d);
        `CHK(d[BIT_START], 1'b0)
        // Free running from the done flag, started by software
        bus_wr(OFS_CTRL_B, 8'h00);
        bus_wr(OFS_CTRL_A, 8'he8);
        repeat (200) @(posedge core_clk_i);
        bus_rd(OFS_CTRL_A, d);
        `CHK(d[BIT_START], 1'b1)
        `CHK(d[BIT_FLAG], 1'b1)
        // Gating power mid-run aborts; ungate then disable, start bit stays low
        bus_wr(OFS_POWER, 8'h01);
        bus_rd(OFS_CTRL_A, d);
        `CHK(d[BIT_START], 1'b0)
        `CHK(power_o, 1'b0)
        bus_wr(OFS_POWER, 8'h00);
        bus_wr(OFS_CTRL_A, 8'h00);
        bus_rd(OFS_CTRL_A, d);
        `CHK(d[BIT_START], 1'b0)
        test_done;
    end
endmodule // tb
